//--- core/csf_status.sv
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module csf_status #(
  parameter int OVCT_W = 16
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          load_page_instr,
  input  wire logic [csf_pkg::DP_W-1:0]      page_value,
  input  wire logic                          load_status0_instr,
  input  wire logic                          load_status1_instr,
  input  wire logic [15:0]                   status_data,
  input  wire logic                          bit_set_instr,
  input  wire logic                          bit_clear_instr,
  input  wire logic [1:0]                    bit_target,
  input  wire logic                          set_product_mode_instr,
  input  wire logic [1:0]                    product_mode_value,
  input  wire logic                          conditional_branch_ov,
  input  wire logic                          bit_test_instr,
  input  wire logic                          dynamic_bit_test_instr,
  input  wire logic                          aux_compare_instr,
  input  wire logic                          test_result,
  input  wire logic                          leading_bit_align_instr,
  input  wire logic [1:0]                    acc_msbs,
  input  wire logic                          mask_irq_req,
  input  wire logic                          nmi_req,
  input  wire logic                          reset_irq_req,
  input  wire logic [csf_pkg::OFS_W-1:0]     direct_offset,
  input  wire logic [csf_pkg::PROD_W-1:0]    product_register,
  input  wire logic                          acc_write,
  input  wire logic [csf_pkg::PROD_W:0]      acc_sum,
  input  wire logic [csf_pkg::DATA_W-1:0]    scale_data,
  input  wire logic [csf_pkg::SHC_W-1:0]     scale_count,
  input  wire logic                          add_unextended_instr,
  output logic [csf_pkg::ADDR_W-1:0]         direct_addr,
  output logic [csf_pkg::PROD_W-1:0]         product_scaled,
  output logic [csf_pkg::PROD_W-1:0]         acc_result,
  output logic [csf_pkg::PROD_W-1:0]         scaled_data,
  output logic [csf_pkg::DP_W-1:0]           data_page_pointer,
  output logic                               global_interrupt_mask,
  output logic                               arith_excess_flag,
  output logic                               saturation_mode_bit,
  output logic [1:0]                         product_shift_select,
  output logic                               sign_extend_mode,
  output logic                               test_condition_flag,
  output logic                               external_flag_pin,
  output logic                               mask_irq_take,
  output logic                               nmi_take,
  output logic                               reset_irq_take,
  output logic [15:0]                        status0_image,
  output logic [15:0]                        status1_image
);
  function automatic logic hit(input logic en, input logic [1:0] sel, input logic [1:0] tgt);
    return en && (sel == tgt);
  endfunction

  logic [csf_pkg::DP_W-1:0]   dp_reg;
  logic [csf_pkg::DP_W-1:0]   dp_next;
  logic                       global_interrupt_mask_reg;
  logic                       global_interrupt_mask_next;
  logic                       ov_reg;
  logic                       ov_next;
  logic                       ovm_reg;
  logic                       ovm_next;
  logic [1:0]                 pm_reg;
  logic [1:0]                 pm_next;
  logic                       sxm_reg;
  logic                       sxm_next;
  logic                       tc_reg;
  logic                       tc_next;
  logic                       xf_reg;
  logic                       xf_next;
  logic [OVCT_W-1:0]          ovct_reg;
  logic [OVCT_W-1:0]          ovct_next;
  logic                       take_m_reg;
  logic                       take_n_reg;
  logic                       take_r_reg;
  logic [csf_pkg::ADDR_W-1:0] addr_reg;
  logic [csf_pkg::PROD_W-1:0] pscale_reg;
  logic [csf_pkg::PROD_W-1:0] acc_reg;
  logic [csf_pkg::PROD_W-1:0] iscale_reg;
  logic [31:0]                prdata_reg;
  logic                       pready_reg;
  logic                       pslverr_reg;

  wire take_m     = mask_irq_req && !global_interrupt_mask_reg;
  wire set_global_interrupt_mask   = hit(bit_set_instr, bit_target, csf_pkg::CSF_BIT_GLOBAL_INTERRUPT_MASK);
  wire clr_global_interrupt_mask   = hit(bit_clear_instr, bit_target, csf_pkg::CSF_BIT_GLOBAL_INTERRUPT_MASK);
  wire set_ovm    = hit(bit_set_instr, bit_target, csf_pkg::CSF_BIT_OVM);
  wire clr_ovm    = hit(bit_clear_instr, bit_target, csf_pkg::CSF_BIT_OVM);
  wire set_sxm    = hit(bit_set_instr, bit_target, csf_pkg::CSF_BIT_SXM);
  wire clr_sxm    = hit(bit_clear_instr, bit_target, csf_pkg::CSF_BIT_SXM);
  wire set_xf     = hit(bit_set_instr, bit_target, csf_pkg::CSF_BIT_XF);
  wire clr_xf     = hit(bit_clear_instr, bit_target, csf_pkg::CSF_BIT_XF);
  wire acc_ovf    = acc_sum[csf_pkg::PROD_W] ^ acc_sum[csf_pkg::PROD_W-1];
  wire ovf_event  = acc_write && acc_ovf;
  wire ov_clear   = conditional_branch_ov || load_status0_instr;
  wire tc_test    = bit_test_instr || dynamic_bit_test_instr || aux_compare_instr;

  // Load-status never touches the mask; trap outranks a same-cycle clear
  assign global_interrupt_mask_next = (take_m || set_global_interrupt_mask) ? 1'b1 : (clr_global_interrupt_mask ? 1'b0 : global_interrupt_mask_reg);
  assign dp_next = load_page_instr ? page_value :
                   load_status0_instr ? status_data[csf_pkg::DP_W-1:0] : dp_reg;
  // A new overflow wins over a clear in the same cycle
  assign ov_next = ovf_event ? 1'b1 :
                   load_status0_instr ? status_data[csf_pkg::ST0_OV] :
                   conditional_branch_ov ? 1'b0 : ov_reg;
  assign ovm_next = set_ovm ? 1'b1 : clr_ovm ? 1'b0 :
                    load_status0_instr ? status_data[csf_pkg::ST0_OVM] : ovm_reg;
  assign pm_next = set_product_mode_instr ? product_mode_value :
                   load_status1_instr ? status_data[csf_pkg::ST1_PMH:0] : pm_reg;
  assign sxm_next = set_sxm ? 1'b1 : clr_sxm ? 1'b0 :
                    load_status1_instr ? status_data[csf_pkg::ST1_SXM] : sxm_reg;
  assign tc_next = leading_bit_align_instr ? (acc_msbs[1] ^ acc_msbs[0]) :
                   tc_test ? test_result :
                   load_status1_instr ? status_data[csf_pkg::ST1_TC] : tc_reg;
  assign xf_next = set_xf ? 1'b1 : clr_xf ? 1'b0 : xf_reg;

  // Event counter saturates rather than wrap; a write to OFS_OVCT clears it
  wire apb_wr  = psel && penable && pready_reg && pwrite;
  wire ct_clr  = apb_wr && (paddr == csf_pkg::OFS_OVCT);
  wire ct_full = &ovct_reg;
  assign ovct_next = ct_clr ? '0 :
                     (ovf_event && !ct_full) ? ovct_reg + 1'b1 : ovct_reg;

  // Shift is applied on the transfer path only, the product input is read-only
  wire [csf_pkg::PROD_W-1:0] ps_val =
    (pm_reg == csf_pkg::PM_LEFT1) ? product_register << csf_pkg::PM_L1 :
    (pm_reg == csf_pkg::PM_LEFT4) ? product_register << csf_pkg::PM_L4 :
    (pm_reg == csf_pkg::PM_RIGHT6) ?
      csf_pkg::PROD_W'($signed(product_register) >>> csf_pkg::PM_R6) :
    product_register;

  wire [csf_pkg::PROD_W-1:0] sat_val = acc_sum[csf_pkg::PROD_W] ? csf_pkg::SAT_NEG
                                                                 : csf_pkg::SAT_POS;
  wire [csf_pkg::PROD_W-1:0] acc_val = (acc_ovf && ovm_reg) ? sat_val
                                     : acc_sum[csf_pkg::PROD_W-1:0];

  wire ext_on = sxm_reg && !add_unextended_instr && scale_data[csf_pkg::DATA_W-1];
  wire [csf_pkg::PROD_W-1:0] is_in = {{csf_pkg::DATA_W{ext_on}}, scale_data};
  wire [csf_pkg::PROD_W-1:0] is_val = is_in << scale_count;

  wire [15:0] st0_val = {3'h0, ov_reg, ovm_reg, 1'b1, global_interrupt_mask_reg, dp_reg};
  wire [15:0] st1_val = {3'h0, 1'b0, tc_reg, sxm_reg, 1'b0, 4'hf, xf_reg, 2'h3, pm_reg};

  wire        ap_setup = psel && !penable && !pready_reg;
  wire        ap_map   = (paddr == csf_pkg::OFS_ST0) || (paddr == csf_pkg::OFS_ST1) ||
                         (paddr == csf_pkg::OFS_OVCT);
  wire [31:0] ap_rd    = (paddr == csf_pkg::OFS_ST0) ? {16'h0000, st0_val} :
                         (paddr == csf_pkg::OFS_ST1) ? {16'h0000, st1_val} :
                         (paddr == csf_pkg::OFS_OVCT) ? 32'(ovct_reg) : 32'h00000000;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_reg   <= csf_pkg::DP_RST;
      global_interrupt_mask_reg <= csf_pkg::GLOBAL_INTERRUPT_MASK_RST;
      ov_reg   <= csf_pkg::OV_RST;
      ovm_reg  <= csf_pkg::OVM_RST;
      pm_reg   <= csf_pkg::PM_RST;
      sxm_reg  <= csf_pkg::SXM_RST;
      tc_reg   <= csf_pkg::TC_RST;
      xf_reg   <= csf_pkg::XF_RST;
      ovct_reg <= '0;
    end
    else
    begin
      dp_reg   <= dp_next;
      global_interrupt_mask_reg <= global_interrupt_mask_next;
      ov_reg   <= ov_next;
      ovm_reg  <= ovm_next;
      pm_reg   <= pm_next;
      sxm_reg  <= sxm_next;
      tc_reg   <= tc_next;
      xf_reg   <= xf_next;
      ovct_reg <= ovct_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      take_m_reg <= 1'b0;
      take_n_reg <= 1'b0;
      take_r_reg <= 1'b0;
      addr_reg   <= '0;
      pscale_reg <= '0;
      acc_reg    <= '0;
      iscale_reg <= '0;
    end
    else
    begin
      take_m_reg <= take_m;
      take_n_reg <= nmi_req;
      take_r_reg <= reset_irq_req;
      addr_reg   <= {dp_reg, direct_offset};
      pscale_reg <= ps_val;
      acc_reg    <= acc_val;
      iscale_reg <= is_val;
    end
  end

  // Zero-wait slave: ready rises for exactly the access cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end
    else
    begin
      pready_reg  <= ap_setup;
      pslverr_reg <= ap_setup && !ap_map;
      prdata_reg  <= (ap_setup && !pwrite) ? ap_rd : 32'h00000000;
    end
  end

  // Flags come straight from state, so the next instruction sees them
  assign data_page_pointer     = dp_reg;
  assign global_interrupt_mask = global_interrupt_mask_reg;
  assign arith_excess_flag     = ov_reg;
  assign saturation_mode_bit   = ovm_reg;
  assign product_shift_select  = pm_reg;
  assign sign_extend_mode      = sxm_reg;
  assign test_condition_flag   = tc_reg;
  assign external_flag_pin     = xf_reg;
  assign mask_irq_take         = take_m_reg;
  assign nmi_take              = take_n_reg;
  assign reset_irq_take        = take_r_reg;
  assign direct_addr           = addr_reg;
  assign product_scaled        = pscale_reg;
  assign acc_result            = acc_reg;
  assign scaled_data           = iscale_reg;
  assign status0_image         = st0_val;
  assign status1_image         = st1_val;
  assign prdata                = prdata_reg;
  assign pready                = pready_reg;
  assign pslverr               = pslverr_reg;

  property p_dp_hold;
    @(posedge mclk) disable iff (!rst_n)
      !load_page_instr && !load_status0_instr |=> $stable(dp_reg);
  endproperty
  a_dp_hold: assert property (p_dp_hold) else $error("page pointer moved");

  property p_addr;
    @(posedge mclk) disable iff (!rst_n)
      1'b1 |=> direct_addr == {$past(dp_reg), $past(direct_offset)};
  endproperty
  a_addr: assert property (p_addr) else $error("direct address wrong");

  property p_mask_block;
    @(posedge mclk) disable iff (!rst_n)
      global_interrupt_mask_reg |=> !mask_irq_take;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked trap taken");

  property p_lst_global_interrupt_mask;
    @(posedge mclk) disable iff (!rst_n)
      load_status0_instr && !bit_set_instr && !bit_clear_instr && !take_m
      |=> $stable(global_interrupt_mask_reg);
  endproperty
  a_lst_global_interrupt_mask: assert property (p_lst_global_interrupt_mask) else $error("load-status hit mask");

  property p_trap_global_interrupt_mask;
    @(posedge mclk) disable iff (!rst_n)
      take_m |=> global_interrupt_mask_reg && mask_irq_take;
  endproperty
  a_trap_global_interrupt_mask: assert property (p_trap_global_interrupt_mask) else $error("trap left mask clear");

  property p_nmi;
    @(posedge mclk) disable iff (!rst_n)
      nmi_req |=> nmi_take;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not taken");

  property p_ov_sticky;
    @(posedge mclk) disable iff (!rst_n)
      (ov_reg && !ov_clear) || ovf_event |=> ov_reg;
  endproperty
  a_ov_sticky: assert property (p_ov_sticky) else $error("overflow flag lost");

  property p_sat;
    @(posedge mclk) disable iff (!rst_n)
      acc_ovf && ovm_reg |=>
        acc_result == ($past(acc_sum[csf_pkg::PROD_W]) ? csf_pkg::SAT_NEG : csf_pkg::SAT_POS);
  endproperty
  a_sat: assert property (p_sat) else $error("no clamp on overflow");

  property p_right6;
    @(posedge mclk) disable iff (!rst_n)
      pm_reg == csf_pkg::PM_RIGHT6 |=>
        product_scaled ==
          csf_pkg::PROD_W'($signed($past(product_register)) >>> csf_pkg::PM_R6);
  endproperty
  a_right6: assert property (p_right6) else $error("right shift wrong");

  property p_tc_hold;
    @(posedge mclk) disable iff (!rst_n)
      !tc_test && !leading_bit_align_instr && !load_status1_instr |=> $stable(tc_reg);
  endproperty
  a_tc_hold: assert property (p_tc_hold) else $error("test flag moved");

  property p_leading_bit_align_instr;
    @(posedge mclk) disable iff (!rst_n)
      leading_bit_align_instr |=> tc_reg == ($past(acc_msbs[1]) ^ $past(acc_msbs[0]));
  endproperty
  a_leading_bit_align_instr: assert property (p_leading_bit_align_instr) else $error("align test wrong");

  property p_rsv;
    @(posedge mclk) disable iff (!rst_n)
      status0_image[csf_pkg::ST0_RSV] && (&status1_image[csf_pkg::ST1_RSVH:csf_pkg::ST1_RSVL])
      && status1_image[csf_pkg::ST1_RSV3] && status1_image[csf_pkg::ST1_RSV2];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit low");
endmodule

//--- include/csf_pkg.sv
package csf_pkg;
  localparam int DP_W    = 9;
  localparam int OFS_W   = 7;
  localparam int ADDR_W  = 16;
  localparam int PROD_W  = 32;
  localparam int DATA_W  = 16;
  localparam int SHC_W   = 5;
  localparam int PM_L1   = 1;
  localparam int PM_L4   = 4;
  localparam int PM_R6   = 6;
  localparam logic [1:0] PM_NONE = 2'h0;
  localparam logic [1:0] PM_LEFT1 = 2'h1;
  localparam logic [1:0] PM_LEFT4 = 2'h2;
  localparam logic [1:0] PM_RIGHT6 = 2'h3;
  // Status word 0 layout
  localparam int ST0_OV   = 12;
  localparam int ST0_OVM  = 11;
  localparam int ST0_RSV  = 10;
  localparam int ST0_GLOBAL_INTERRUPT_MASK = 9;
  // Status word 1 layout
  localparam int ST1_TC   = 11;
  localparam int ST1_SXM  = 10;
  localparam int ST1_RSVH = 8;
  localparam int ST1_RSVL = 5;
  localparam int ST1_XF   = 4;
  localparam int ST1_RSV3 = 3;
  localparam int ST1_RSV2 = 2;
  localparam int ST1_PMH  = 1;
  // Reset values and accumulator saturation limits
  localparam logic [DP_W-1:0] DP_RST = 9'h000;
  localparam logic GLOBAL_INTERRUPT_MASK_RST = 1'b1;
  localparam logic OV_RST   = 1'b0;
  localparam logic OVM_RST  = 1'b0;
  localparam logic [1:0] PM_RST = 2'h0;
  localparam logic SXM_RST  = 1'b1;
  localparam logic TC_RST   = 1'b0;
  localparam logic XF_RST   = 1'b1;
  localparam logic [PROD_W-1:0] SAT_POS = 32'h7fffffff;
  localparam logic [PROD_W-1:0] SAT_NEG = 32'h80000000;
  // APB map
  localparam logic [7:0] OFS_ST0  = 8'h00;
  localparam logic [7:0] OFS_ST1  = 8'h04;
  localparam logic [7:0] OFS_OVCT = 8'h08;
  typedef enum logic [1:0] {
    CSF_BIT_GLOBAL_INTERRUPT_MASK = 2'h0,
    CSF_BIT_OVM  = 2'h1,
    CSF_BIT_SXM  = 2'h3,
    CSF_BIT_XF   = 2'h2
  } csf_bit_t;
endpackage

//--- tb/csf_decoder_model.sv
`timescale 1ns/1ps
// Stands in for the instruction decoder: one opcode, one strobe
module csf_decoder_model (
  input  wire logic [3:0] op,
  output logic            load_page_instr,
  output logic            load_status0_instr,
  output logic            load_status1_instr,
  output logic            bit_set_instr,
  output logic            bit_clear_instr,
  output logic            set_product_mode_instr,
  output logic            conditional_branch_ov,
  output logic            bit_test_instr,
  output logic            dynamic_bit_test_instr,
  output logic            aux_compare_instr,
  output logic            leading_bit_align_instr,
  output logic            acc_write,
  output logic            add_unextended_instr
);
  // Opcode zero is idle, so never two strobes at once
  wire [13:0] hot = 14'h0001 << op;
  assign {add_unextended_instr, acc_write, leading_bit_align_instr, aux_compare_instr,
          dynamic_bit_test_instr, bit_test_instr, conditional_branch_ov,
          set_product_mode_instr, bit_clear_instr, bit_set_instr, load_status1_instr,
          load_status0_instr, load_page_instr} = hot[13:1];
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top;
  typedef struct { int s; logic [32:0] v; } csf_note_t;
  logic mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd_val;
  logic pready, pslverr, rd_err;
  logic [3:0] op = 4'h0;
  logic load_page_instr, load_status0_instr, load_status1_instr, bit_set_instr;
  logic bit_clear_instr, set_product_mode_instr, conditional_branch_ov, bit_test_instr;
  logic dynamic_bit_test_instr, aux_compare_instr, leading_bit_align_instr, acc_write;
  logic add_unextended_instr;
  logic [csf_pkg::DP_W-1:0] page_value = 9'h000, data_page_pointer, e_pg;
  logic [15:0] status_data = 16'h0, scale_data = 16'h0, status0_image, status1_image;
  logic [1:0] bit_target = 2'h0, product_mode_value = 2'h0, acc_msbs = 2'h0;
  logic [1:0] product_shift_select, e_pm;
  logic test_result = 1'b0, mask_irq_req = 1'b0, nmi_req = 1'b0, reset_irq_req = 1'b0;
  logic [csf_pkg::OFS_W-1:0] direct_offset = 7'h00;
  logic [31:0] product_register = 32'h0, product_scaled, acc_result, scaled_data, r;
  logic [32:0] acc_sum = 33'h0;
  logic [4:0] scale_count = 5'h0;
  logic [csf_pkg::ADDR_W-1:0] direct_addr;
  logic global_interrupt_mask, arith_excess_flag, saturation_mode_bit, sign_extend_mode;
  logic test_condition_flag, external_flag_pin, mask_irq_take, nmi_take, reset_irq_take;
  logic e_im, e_ov, e_sm, e_sx, e_tc, e_xf, v;
  logic [31:0] seed = 32'h00012c56;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  csf_note_t notes [$];
  csf_note_t nt;
  string nm [9] = '{"state", "daddr", "pscaled", "accres", "scaled", "takes", "apbrd",
                    "img0", "img1"};

  csf_status dut_u (.*);
  csf_decoder_model dec_u (.*);

  always #50 mclk = ~mclk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [32:0] seen(int s);
    case (s)
      0: return {data_page_pointer, global_interrupt_mask, arith_excess_flag,
                 saturation_mode_bit, product_shift_select, sign_extend_mode,
                 test_condition_flag, external_flag_pin};
      1: return direct_addr;
      2: return product_scaled;
      3: return acc_result;
      4: return scaled_data;
      5: return {mask_irq_take, nmi_take, reset_irq_take};
      6: return {rd_err, rd_val};
      7: return status0_image;
      default: return status1_image;
    endcase
  endfunction

  function automatic logic [15:0] img0();
    return {3'h0, e_ov, e_sm, 1'b1, e_im, e_pg};
  endfunction

  function automatic logic [15:0] img1();
    return {4'h0, e_tc, e_sx, 1'b0, 4'hf, e_xf, 2'h3, e_pm};
  endfunction

  function automatic logic [31:0] pshift(logic [1:0] m, logic [31:0] p);
    case (m)
      csf_pkg::PM_LEFT1: return p << csf_pkg::PM_L1;
      csf_pkg::PM_LEFT4: return p << csf_pkg::PM_L4;
      csf_pkg::PM_RIGHT6: return $signed(p) >>> csf_pkg::PM_R6;
      default: return p;
    endcase
  endfunction

  task automatic note(int s, logic [32:0] x);
    notes.push_back('{s, x});
  endtask

  task automatic chk_state();
    note(0, {e_pg, e_im, e_ov, e_sm, e_pm, e_sx, e_tc, e_xf});
    note(7, img0());
    note(8, img1());
  endtask

  // Strobe lowered one edge before the next opcode may go up
  task automatic run(logic [3:0] o);
    op <= o;
    @(posedge mclk);
    op <= 4'h0;
    @(posedge mclk);
  endtask

  task automatic bit_op(logic [1:0] t, logic val);
    bit_target <= t;
    run(val ? 4'h4 : 4'h5);
    if (t == csf_pkg::CSF_BIT_GLOBAL_INTERRUPT_MASK) e_im = val;
    if (t == csf_pkg::CSF_BIT_OVM) e_sm = val;
    if (t == csf_pkg::CSF_BIT_XF) e_xf = val;
    if (t == csf_pkg::CSF_BIT_SXM) e_sx = val;
  endtask

  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Sample between edges; the completing edge is the next rising one
    @(negedge mclk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(negedge mclk);
      n++;
    end
    if (n == 50) n_errors++;
    rd_val = prdata;
    rd_err = pslverr;
    @(posedge mclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic irq(logic [2:0] req, logic [2:0] exp_take);
    {mask_irq_req, nmi_req, reset_irq_req} <= req;
    @(posedge mclk);
    {mask_irq_req, nmi_req, reset_irq_req} <= 3'h0;
    note(5, exp_take);
    @(posedge mclk);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(negedge mclk)
  begin
    while (notes.size() > 0)
    begin
      nt = notes.pop_front();
      `CHK(nm[nt.s], nt.v, seen(nt.s))
    end
  end

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end

  initial
  begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    {e_pg, e_im, e_ov, e_sm, e_pm, e_sx, e_tc, e_xf} = {9'h000, 1'b1, 2'h0, 2'h0, 1'b1,
                                                      1'b0, 1'b1};
    @(posedge mclk);
    chk_state();
    apb(1'b0, csf_pkg::OFS_ST0, 32'h0);
    note(6, {1'b0, 16'h0, img0()});
    apb(1'b1, csf_pkg::OFS_ST1, 32'hffffffff);
    apb(1'b0, csf_pkg::OFS_ST1, 32'h0);
    note(6, {1'b0, 16'h0, img1()});
    apb(1'b0, 8'h0c, 32'h0);
    note(6, {1'b1, 32'h0});
    chk_state();
    $display("test reset and bus done");
    for (int k = 0; k < 8; k++)
    begin
      bit_op(k[1:0], k[2]);
      chk_state();
    end
    $display("test bit set and clear done");
    r = rnd();
    page_value <= r[8:0];
    direct_offset <= r[15:9];
    run(4'h1);
    e_pg = r[8:0];
    chk_state();
    note(1, {r[8:0], r[15:9]});
    r = rnd();
    status_data <= r[15:0];
    run(4'h2);
    {e_ov, e_sm, e_pg} = {r[12], r[11], r[8:0]};
    chk_state();
    r = rnd();
    status_data <= r[15:0];
    run(4'h3);
    {e_tc, e_sx, e_pm} = {r[11], r[10], r[1:0]};
    chk_state();
    $display("test page and load status done");
    for (int k = 0; k < 4; k++)
    begin
      r = rnd();
      product_mode_value <= k[1:0];
      product_register <= r;
      run(4'h6);
      e_pm = k[1:0];
      chk_state();
      note(2, pshift(e_pm, r));
    end
    $display("test product shift done");
    for (int k = 0; k < 2; k++)
    begin
      bit_op(csf_pkg::CSF_BIT_OVM, k[0]);
      r = rnd();
      acc_sum <= {k[0], ~k[0], r[30:0]};
      run(4'hc);
      e_ov = 1'b1;
      note(3, k[0] ? csf_pkg::SAT_NEG : {1'b1, r[30:0]});
      chk_state();
      acc_sum <= {2'h0, r[30:0]};
      run(4'hc);
      note(3, {1'b0, r[30:0]});
      chk_state();
      run(4'h7);
      e_ov = 1'b0;
      chk_state();
    end
    apb(1'b0, csf_pkg::OFS_OVCT, 32'h0);
    note(6, {1'b0, 32'h00000002});
    apb(1'b1, csf_pkg::OFS_OVCT, 32'h0);
    apb(1'b0, csf_pkg::OFS_OVCT, 32'h0);
    note(6, {1'b0, 32'h00000000});
    $display("test overflow done");
    for (int k = 0; k < 8; k++)
    begin
      v = k[0] ^ k[2];
      test_result <= (k[1:0] == 2'h3) ? ~v : v;
      acc_msbs <= (k[1:0] == 2'h3) ? {v, 1'b0} : {~v, 1'b0};
      run(4'h8 + k[1:0]);
      e_tc = v;
      chk_state();
    end
    $display("test condition flag done");
    irq(3'h7, 3'h3);
    bit_op(csf_pkg::CSF_BIT_GLOBAL_INTERRUPT_MASK, 1'b0);
    irq(3'h4, 3'h4);
    e_im = 1'b1;
    chk_state();
    bit_op(csf_pkg::CSF_BIT_GLOBAL_INTERRUPT_MASK, 1'b0);
    irq(3'h2, 3'h2);
    $display("test interrupts done");
    for (int k = 0; k < 4; k++)
    begin
      bit_op(csf_pkg::CSF_BIT_SXM, k[0]);
      r = rnd();
      scale_data <= {1'b1, r[14:0]};
      scale_count <= 5'(r[20:16] % 17);
      op <= k[1] ? 4'hd : 4'h0;
      @(posedge mclk);
      op <= 4'h0;
      note(4, (k[0] & ~k[1]) ? 32'({16'hffff, 1'b1, r[14:0]} << (r[20:16] % 17))
                             : 32'({16'h0, 1'b1, r[14:0]} << (r[20:16] % 17)));
      @(posedge mclk);
    end
    $display("test scaling shifter done");
    @(posedge mclk);
    report_and_stop();
  end
endmodule
